// File: hw/adc_gain_loop_consts.vh
// constants for the adc record-path gain loop: offsets, fields, resets, timing
`ifndef ADC_GAIN_LOOP_CONSTS_VH
`define ADC_GAIN_LOOP_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_CTRL_THREE     6'h22
`define IDX_QUIET_GATE     6'h23
`define IDX_LOOP_CTRL      6'h24
`define IDX_LOOP_STATUS    6'h25

// control three fields
`define F_MODE_BIT         8
`define F_UP_HI            7
`define F_UP_LO            4
`define F_DOWN_HI          3
`define F_DOWN_LO          0
`define RST_CTRL_THREE     9'h032

// quiet gate fields
`define F_QTH_HI           2
`define F_QTH_LO           0
`define F_QEN_BIT          3
`define RST_QUIET_GATE     9'h000

// loop control fields
`define F_EN_BIT           0
`define F_TGT_HI           7
`define F_TGT_LO           4
`define F_STAT_HI          13
`define F_STAT_LO          8
`define RST_LOOP_CTRL      14'h10B0

// status fields
`define F_GATED_BIT        8
`define F_CLIP_BIT         9

// level arithmetic in 0.75 dB units; full scale level code
`define LVL_FULL_SCALE     127
// target -28.5 dBFS in units, 1.5 dB per code
`define TGT_BASE_U         (`LVL_FULL_SCALE - 38)
`define TGT_STEP_U         2
// gate -39 dBFS in units, 6 dB per code, pga gain code 0 is -12 dB
`define GATE_BASE_U        (`LVL_FULL_SCALE - 52 - 16)
`define GATE_STEP_U        8
`define GAIN_MAX           6'h3F
// seven eighths of full scale on a 16-bit magnitude
`define CLIP_MAG           16'h7000

// ramp timing, times as printed, counts in sample periods
`define FS_HZ              48000
`define STEPS_PER_6DB      8
`define DECAY_6DB_US       3300
`define ATTACK_6DB_US      832
`define DECAY_STEP_SMP     ((`DECAY_6DB_US * `FS_HZ) / (`STEPS_PER_6DB * 1000000))
`define ATTACK_STEP_SMP    ((`ATTACK_6DB_US * `FS_HZ) / (`STEPS_PER_6DB * 1000000))
`define RATE_CODE_MAX      4'hA
`define LIMITER_SHIFT      2

`endif

// File: hw/level_to_units.v
// converts a sample magnitude into a log level in 0.75 dB units
`default_nettype none
module level_to_units (
  input  wire [15:0] mag,   // sample magnitude
  output reg  [6:0]  lvl    // level code, 127 is full scale
);
  integer     i;
  reg   [3:0] msb;  // leading one position
  reg  [15:0] norm; // magnitude shifted to put the leading one at bit 15

  // leading one gives 6 dB octaves, next three bits the fraction
  always @* begin
    msb = 4'h0;
    for (i = 0; i < 16; i = i + 1) begin
      if (mag[i]) begin
        msb = i[3:0];
      end
    end
    norm = mag << (4'hF - msb);
    if (mag == 16'h0000) begin
      lvl = 7'h00;
    end else begin
      lvl = {msb, norm[14:12]};
    end
  end
endmodule
`default_nettype wire

// File: hw/ramp_step_timer.v
// counts sample periods and emits one step pulse per programmed interval
`default_nettype none
`include "adc_gain_loop_consts.vh"
module ramp_step_timer #(
  parameter [15:0] BASE = 16'h0001  // samples per gain step at code zero
) (
  input  wire       clk,      // system clock
  input  wire       nrst,     // async reset, active low
  input  wire       run,      // interval counting allowed
  input  wire       smp_tick, // one pulse per audio sample
  input  wire [3:0] code,     // rate code, doubles per step
  input  wire       fast,     // limiter mode, quarter interval
  output wire       step      // one-cycle step pulse
);
  reg  [15:0] cnt_r;     // samples counted in this interval
  reg  [15:0] period;    // interval length in samples
  reg  [3:0]  code_sat;  // codes above the top act as the top

  // interval follows the sample rate since it counts samples
  always @* begin
    code_sat = (code > `RATE_CODE_MAX) ? `RATE_CODE_MAX : code;
    period = BASE << code_sat;
    if (fast) begin
      period = period >> `LIMITER_SHIFT;
    end
    if (period == 16'h0000) begin
      period = 16'h0001;
    end
  end

  assign step = run && smp_tick && (cnt_r + 16'h0001 >= period);

  // restart the interval whenever counting stops, so no stale credit
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 16'h0000;
    end else if (!run || step) begin
      cnt_r <= 16'h0000;
    end else if (smp_tick) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: hw/adc_gain_loop.v
// record-path gain loop: level control, limiter, clip guard, quiet gate, wishbone regs
// Operation
// [RULE_01] mode bit one selects limiter, zero level control
// [RULE_02] ramp-up interval doubles per code from 3.3ms
// [RULE_03] ramp-down interval doubles per code from 832us
// [RULE_04] limiter mode steps four times faster
// [RULE_05] above seven-eighths scale, ramp down at fastest rate
// [RULE_06] clip guard always active while loop enabled
// [RULE_07] ramp-down code zero makes clip guard invisible
// [RULE_08] gated when level below threshold plus gains
// [RULE_09] gated condition freezes gain against ramping up
// [RULE_10] threshold code zero -39dB, minus 6dB per code
// [RULE_11] gate bit three enables quiet gating
// [RULE_12] gate acts only with loop enabled
// [RULE_13] software avoids extreme gate thresholds
// [RULE_14] reset values: mode 0, up 0011, down 0010
// [RULE_15] ramp timing counted in audio sample periods
`default_nettype none
`include "adc_gain_loop_consts.vh"
module adc_gain_loop (
  input  wire        clk,          // 200 MHz system clock
  input  wire        nrst,         // async reset, active low
  input  wire        wb_cyc_i,     // wishbone cycle
  input  wire        wb_stb_i,     // wishbone strobe
  input  wire        wb_we_i,      // wishbone write enable
  input  wire [7:0]  wb_adr_i,     // wishbone byte address
  input  wire [3:0]  wb_sel_i,     // wishbone byte selects
  input  wire [31:0] wb_dat_i,     // wishbone write data
  output reg  [31:0] wb_dat_o,     // wishbone read data
  output reg         wb_ack_o,     // wishbone acknowledge
  input  wire        smp_valid,    // one pulse per adc sample
  input  wire [15:0] adc_sample,   // signed adc sample
  input  wire [5:0]  mic_boost_u,  // mic boost gain in 0.75 dB units
  output reg  [5:0]  pga_gain_r,   // amplifier gain code, 0.75 dB steps
  output reg         gated_r,      // quiet gate holding the gain
  output reg         clip_r        // clip guard active
);
  // software registers
  reg  [8:0]  ctrl_three_r;   // mode, ramp-up and ramp-down codes
  reg  [8:0]  quiet_gate_r;   // gate threshold and gate enable
  reg  [13:0] loop_ctrl_r;    // loop enable, target, static gain

  // loop state
  reg  [6:0]  peak_r;         // peak level since last gain step
  reg  [6:0]  peak_nxt;       // peak including current sample
  reg  [15:0] mag;            // sample magnitude
  wire [6:0]  lvl;            // sample level in 0.75 dB units
  reg  [10:0] gate_lim;       // gate limit in absolute level units
  reg  [10:0] tgt_lvl;        // target level in absolute level units
  reg         want_down;      // level above target
  reg         want_up;        // level below target and room to rise
  reg         quiet;          // gated condition on this sample
  wire        step_up;        // ramp-up timer step
  wire        step_down;      // ramp-down timer step
  wire        clip_now;       // current sample above clip level
  reg  [6:0]  lvl_v;          // level of a valid sample, zero between pulses
  reg         clip_act;       // clip state the down timer runs on
  reg         quiet_act;      // gate state the up timer runs on
  reg  [5:0]  pga_gain_nxt;   // next amplifier gain code
  reg  [6:0]  peak_upd;       // next running peak
  reg         gated_nxt;      // next quiet gate flag
  reg         clip_nxt;       // next clip flag
  reg  [8:0]  ctrl_three_nxt; // next control three word
  reg  [8:0]  quiet_gate_nxt; // next quiet gate word
  reg  [13:0] loop_ctrl_nxt;  // next loop control word
  reg  [31:0] rd_mux;         // read word for the ack cycle

  // sized copies of the shared constants; each is cut on purpose to the width
  // of the datapath that uses it, so no assignment silently drops bits
  localparam integer GATE_BASE_I = `GATE_BASE_U;                    // gate base as integer
  localparam integer TGT_BASE_I  = `TGT_BASE_U;                     // target base as integer
  localparam integer ATK_STEP_I  = `ATTACK_STEP_SMP;                // samples per down step
  localparam integer DCY_STEP_I  = `DECAY_STEP_SMP;                 // samples per up step
  localparam [13:0]  RST_LOOP_V  = `RST_LOOP_CTRL;                  // loop control reset word
  localparam [10:0]  GATE_BASE_V = GATE_BASE_I[10:0];               // gate base, level width
  localparam [10:0]  TGT_BASE_V  = TGT_BASE_I[10:0];                // target base, level width
  localparam [15:0]  ATK_STEP_V  = ATK_STEP_I[15:0];                // down step, timer width
  localparam [15:0]  DCY_STEP_V  = DCY_STEP_I[15:0];                // up step, timer width
  localparam [5:0]   RST_GAIN_V  = RST_LOOP_V[`F_STAT_HI:`F_STAT_LO]; // static gain at reset

  // field views
  wire        mode_lim   = ctrl_three_r[`F_MODE_BIT];
  wire [3:0]  up_code    = ctrl_three_r[`F_UP_HI:`F_UP_LO];
  wire [3:0]  down_code  = ctrl_three_r[`F_DOWN_HI:`F_DOWN_LO];
  wire [2:0]  qth_code   = quiet_gate_r[`F_QTH_HI:`F_QTH_LO];
  wire        qen        = quiet_gate_r[`F_QEN_BIT];
  wire        loop_en    = loop_ctrl_r[`F_EN_BIT];
  wire [3:0]  tgt_code   = loop_ctrl_r[`F_TGT_HI:`F_TGT_LO];
  wire [5:0]  stat_gain  = loop_ctrl_r[`F_STAT_HI:`F_STAT_LO];

  // bus decode
  wire        bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [5:0]  reg_idx    = wb_adr_i[7:2];
  // a write lands at the edge that shows the ack, while the master still holds it
  wire        wr         = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // magnitude of a signed sample; -32768 maps to 0x8000
  always @* begin
    if (adc_sample[15]) begin
      mag = ~adc_sample + 16'h0001;
    end else begin
      mag = adc_sample;
    end
  end

  level_to_units u_level (
    .mag (mag),
    .lvl (lvl)
  );

  // the sample lane means something only in its valid cycle; between pulses it may
  // carry anything, so decisions fall back on the registered peak and flags
  assign clip_now = smp_valid && (mag > `CLIP_MAG); // RULE_05

  // level of a valid sample only
  always @* begin
    if (smp_valid) begin
      lvl_v = lvl;
    end else begin
      lvl_v = 7'h00; // no sample, no level
    end
  end

  // peak seen since the last step, current sample folded in
  always @* begin
    peak_nxt = (lvl_v > peak_r) ? lvl_v : peak_r;
  end

  // thresholds and decisions, all in 0.75 dB level units
  always @* begin
    // threshold -39 dB falling 6 dB per code
    gate_lim = GATE_BASE_V - {5'h00, qth_code, 3'b000}
             + {5'h00, pga_gain_r} + {5'h00, mic_boost_u}; // RULE_10
    tgt_lvl  = TGT_BASE_V + {6'h00, tgt_code, 1'b0};
    // compared as signed so a very low limit never wraps to a high one
    quiet    = loop_en && qen
             && ($signed({4'h0, peak_nxt}) < $signed(gate_lim)); // RULE_08 RULE_11 RULE_12
    want_down = {4'h0, peak_nxt} > tgt_lvl;
    if (mode_lim) begin
      // limiter only restores up to the static gain
      want_up = !want_down && (pga_gain_r < stat_gain); // RULE_01
    end else begin
      want_up = ({4'h0, peak_nxt} < tgt_lvl) && (pga_gain_r < `GAIN_MAX); // RULE_01
    end
  end

  // between samples the timers run on the flags of the last sample, so an
  // interval is not restarted by every idle clock
  always @* begin
    if (smp_valid) begin
      clip_act  = clip_now;
      quiet_act = quiet;
    end else begin
      clip_act  = clip_r;  // last sample's clip state
      quiet_act = gated_r; // last sample's gate state
    end
  end

  // ramp-down timer, clip guard forces the fastest code
  ramp_step_timer #(
    .BASE (ATK_STEP_V)
  ) u_down (
    .clk      (clk),
    .nrst     (nrst),
    .run      (loop_en && (want_down || clip_act)), // RULE_06
    .smp_tick (smp_valid),                          // RULE_15
    .code     (clip_act ? 4'h0 : down_code),        // RULE_03 RULE_05 RULE_07
    .fast     (mode_lim),                           // RULE_04
    .step     (step_down)
  );

  // ramp-up timer, frozen while gated or clipping
  ramp_step_timer #(
    .BASE (DCY_STEP_V)
  ) u_up (
    .clk      (clk),
    .nrst     (nrst),
    .run      (loop_en && want_up && !want_down && !clip_act && !quiet_act), // RULE_09
    .smp_tick (smp_valid),                                               // RULE_15
    .code     (up_code),                                                 // RULE_02
    .fast     (mode_lim),                                                // RULE_04
    .step     (step_up)
  );

  // next gain, peak and flags; a step clears the peak so each interval judges
  // fresh samples only
  always @* begin
    pga_gain_nxt = pga_gain_r; // hold between samples
    peak_upd     = peak_r;
    gated_nxt    = gated_r;
    clip_nxt     = clip_r;
    if (!loop_en) begin
      // disabled loop simply follows the static gain
      pga_gain_nxt = stat_gain;
      peak_upd     = 7'h00;
      gated_nxt    = 1'b0; // RULE_12
      clip_nxt     = 1'b0;
    end else if (smp_valid) begin
      // flags follow the latest sample
      gated_nxt = quiet;    // RULE_09
      clip_nxt  = clip_now; // RULE_05
      if (step_down) begin
        peak_upd = 7'h00;
        if (pga_gain_r != 6'h00) begin
          pga_gain_nxt = pga_gain_r - 6'h01; // RULE_03
        end
      end else if (step_up) begin
        // the up run condition already keeps the code below its ceiling
        pga_gain_nxt = pga_gain_r + 6'h01; // RULE_02
        peak_upd     = 7'h00;
      end else begin
        peak_upd = peak_nxt; // running peak
      end
    end
  end

  // gain and flag registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pga_gain_r <= RST_GAIN_V; // static gain of the reset loop control word
      peak_r     <= 7'h00;
      gated_r    <= 1'b0;
      clip_r     <= 1'b0;
    end else begin
      pga_gain_r <= pga_gain_nxt;
      peak_r     <= peak_upd;
      gated_r    <= gated_nxt;
      clip_r     <= clip_nxt;
    end
  end

  // register writes, byte lanes honoured, reserved bits dropped
  always @* begin
    ctrl_three_nxt = ctrl_three_r; // unwritten registers hold
    quiet_gate_nxt = quiet_gate_r;
    loop_ctrl_nxt  = loop_ctrl_r;
    if (wr) begin
      case (reg_idx)
        `IDX_CTRL_THREE: begin
          if (wb_sel_i[0]) begin
            ctrl_three_nxt[7:0] = wb_dat_i[7:0]; // RULE_02 RULE_03
          end
          if (wb_sel_i[1]) begin
            ctrl_three_nxt[8] = wb_dat_i[8]; // RULE_01
          end
        end
        `IDX_QUIET_GATE: begin
          if (wb_sel_i[0]) begin
            quiet_gate_nxt = {5'h00, wb_dat_i[3:0]}; // RULE_10 RULE_11
          end
        end
        `IDX_LOOP_CTRL: begin
          if (wb_sel_i[0]) begin
            loop_ctrl_nxt[7:0] = {wb_dat_i[7:4], 3'b000, wb_dat_i[0]};
          end
          if (wb_sel_i[1]) begin
            loop_ctrl_nxt[13:8] = wb_dat_i[13:8];
          end
        end
        default: begin
          // unmapped or read-only: write ignored, still acknowledged
        end
      endcase
    end
  end

  // software registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_three_r <= `RST_CTRL_THREE; // RULE_14
      quiet_gate_r <= `RST_QUIET_GATE; // RULE_14
      loop_ctrl_r  <= `RST_LOOP_CTRL;
    end else begin
      ctrl_three_r <= ctrl_three_nxt;
      quiet_gate_r <= quiet_gate_nxt;
      loop_ctrl_r  <= loop_ctrl_nxt;
    end
  end

  // read word, chosen at the request edge so it stands in the ack cycle
  always @* begin
    rd_mux = 32'h00000000; // zero outside reads keeps the data lines quiet
    if (bus_req && !wb_we_i) begin
      case (reg_idx)
        `IDX_CTRL_THREE:  rd_mux = {23'h000000, ctrl_three_r};
        `IDX_QUIET_GATE:  rd_mux = {23'h000000, quiet_gate_r};
        `IDX_LOOP_CTRL:   rd_mux = {18'h00000, loop_ctrl_r};
        `IDX_LOOP_STATUS: rd_mux = {22'h000000, clip_r, gated_r, 2'b00, pga_gain_r};
        default:          rd_mux = 32'h00000000; // unmapped addresses read zero
      endcase
    end
  end

  // single-cycle ack with its read word
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// File: sim/adc_gain_loop_chk.sv
// port assertions for the gain loop
`default_nettype none
`include "adc_gain_loop_consts.vh"
module adc_gain_loop_chk (
  input wire logic        clk,        // clock
  input wire logic        nrst,       // reset, low
  input wire logic        wb_cyc_i,   // cycle
  input wire logic        wb_stb_i,   // strobe
  input wire logic        wb_we_i,    // write
  input wire logic [7:0]  wb_adr_i,   // address
  input wire logic [31:0] wb_dat_i,   // write data
  input wire logic [31:0] wb_dat_o,   // read data
  input wire logic        wb_ack_o,   // ack
  input wire logic        smp_valid,  // sample strobe
  input wire logic [15:0] adc_sample, // sample
  input wire logic [5:0]  pga_gain_r, // gain
  input wire logic        gated_r,    // gate
  input wire logic        clip_r      // clip
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        en_r;  // loop enable copy
  logic        qen_r; // gate enable copy
  logic [15:0] mag;   // sample magnitude
  logic        big;   // above seven eighths
  assign mag = adc_sample[15] ? -adc_sample : adc_sample;
  assign big = mag > `CLIP_MAG;
  // copy enables at the ack edge, as the registers do
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_r  <= 1'b0;
      qen_r <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
      if (wb_adr_i[7:2] == `IDX_LOOP_CTRL) en_r <= wb_dat_i[0];
      if (wb_adr_i[7:2] == `IDX_QUIET_GATE) qen_r <= wb_dat_i[3];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_resp;
    s_take |=> s_pulse;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack late or long");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_stb_i) && !$past(wb_ack_o);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_zero;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
  property p_clip;
    en_r && smp_valid |=> clip_r == $past(big);
  endproperty
  a_clip: assert property (p_clip) else $error("clip flag wrong");
  property p_clip_hold;
    $past(en_r) && $past(clip_r) && clip_r |-> pga_gain_r <= $past(pga_gain_r);
  endproperty
  a_clip_hold: assert property (p_clip_hold) else $error("gain rose in clip");
  property p_gate_hold;
    $past(en_r) && $past(gated_r) && gated_r |-> pga_gain_r <= $past(pga_gain_r);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gain rose gated");
  property p_gate_cause;
    $rose(gated_r) |-> $past(en_r) && $past(qen_r) && $past(smp_valid);
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("gate bad cause");
  property p_gain_step;
    $past(en_r) && $changed(pga_gain_r) |-> $past(smp_valid);
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("gain off sample");
endmodule
bind adc_gain_loop adc_gain_loop_chk i_chk (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .smp_valid, .adc_sample, .pga_gain_r,
  .gated_r, .clip_r);
`default_nettype wire

// File: sim/adc_src_model.sv
// sample source in place of amplifier and adc
`default_nettype none
module adc_src_model (
  input  wire logic        clk,       // clock
  input  wire logic        nrst,      // reset, low
  input  wire logic [3:0]  gap,       // idle clocks per sample
  input  wire logic [15:0] amp,       // magnitude
  output var  logic        smp_valid, // sample pulse
  output var  logic [15:0] adc_sample // signed sample
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r; // clocks to next sample
  logic       neg_r; // sign of next sample
  // alternating sign; off the pulse the data is inverted every clock, so the stale value returns on every other idle clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r      <= 4'h0;
      neg_r      <= 1'b0;
      smp_valid  <= 1'b0;
      adc_sample <= 16'h0000;
    end else if (cnt_r == 4'h0) begin
      cnt_r      <= gap;
      neg_r      <= !neg_r;
      smp_valid  <= 1'b1;
      adc_sample <= neg_r ? -amp : amp;
    end else begin
      cnt_r      <= cnt_r - 4'h1;
      smp_valid  <= 1'b0;
      adc_sample <= ~adc_sample;
    end
  end
endmodule
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the gain loop
`default_nettype none
`include "adc_gain_loop_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TGT = `TGT_BASE_U + `TGT_STEP_U * 11; // target code 1011
  logic        clk = 1'b0;         // 200 MHz
  logic        nrst = 1'b0;        // reset, low
  logic        wb_cyc_i = 1'b0;    // bus drive
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd, v;    // read data, captured, random
  logic        wb_ack_o, smp_valid, gated_r, clip_r;
  logic [15:0] adc_sample;
  logic [15:0] amp = 16'h0000;     // source magnitude
  logic [5:0]  mic_boost_u = 6'h00;
  logic [5:0]  pga_gain_r;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  always #2.5 clk = ~clk;
  adc_gain_loop i_dut (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .smp_valid, .adc_sample,
    .mic_boost_u, .pga_gain_r, .gated_r, .clip_r);
  adc_src_model i_src (.clk, .nrst, .gap(4'h7), .amp, .smp_valid, .adc_sample);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one classic cycle; held until ack is seen
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic smps(input int n);
    repeat (n) do @(posedge clk); while (smp_valid !== 1'b1);
  endtask
  // level in 0.75 dB units: msb position times 8 plus next three bits
  function automatic int lvl(input logic [15:0] s);
    logic [15:0] m;
    m = s[15] ? -s : s;
    lvl = 0;
    for (int b = 3; b < 16; b++) if (m[b]) lvl = b * 8 + m[b-1 -: 3];
  endfunction
  // signed gain steps expected after n samples
  function automatic int exp_steps(input logic [8:0] c, input logic [15:0] s, input int n);
    logic [15:0] m;
    int          iv;
    m = s[15] ? -s : s;
    if (lvl(s) > TGT) iv = `ATTACK_STEP_SMP << (m > `CLIP_MAG ? 0 : (c[3:0] > 10 ? 10 : c[3:0]));
    else iv = `DECAY_STEP_SMP << (c[7:4] > 10 ? 10 : c[7:4]);
    if (c[8]) iv = iv / 4;
    exp_steps = n / iv;
    if (lvl(s) > TGT) exp_steps = -exp_steps;
    else if (c[8]) exp_steps = 0;
  endfunction
  // restart loop from static gain 0x20, run 40 samples, judge the drift
  task automatic ramp(input logic [8:0] c, input logic [15:0] s);
    int e;
    int g;
    wb(1'b1, 8'h90, 32'h0000_20B0);
    wb(1'b1, 8'h88, {23'h0, c});
    amp <= s;
    wb(1'b1, 8'h90, 32'h0000_20B1);
    smps(40);
    @(posedge clk); // last sample's step settles before the gain is read
    e = exp_steps(c, s, 40);
    g = int'(pga_gain_r) - 32;
    check({31'h0, g == e || (e < 0 && g == e + 1) || (e > 0 && g == e - 1)}, 32'h1);
  endtask
  // quiet input against the gate, then gain must hold exactly when gated
  task automatic gate(input logic [3:0] q, input logic [5:0] b);
    logic e;
    wb(1'b1, 8'h90, 32'h0000_20B0);
    wb(1'b1, 8'h88, 32'h0); // fastest up interval, so an ungated run must rise
    wb(1'b1, 8'h8C, {28'h0, q});
    mic_boost_u <= b;
    amp <= 16'h0100;
    wb(1'b1, 8'h90, 32'h0000_20B1);
    smps(30);
    @(posedge clk); // flags of the last sample settle first
    e = q[3] && (lvl(16'h0100) < `GATE_BASE_U - `GATE_STEP_U * int'(q[2:0]) + 32 + b);
    check({31'h0, gated_r}, {31'h0, e});
    check({31'h0, pga_gain_r == 6'h20}, {31'h0, e});
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(94836));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    wb(1'b0, 8'h88, 32'h0);
    check(rd, 32'h0000_0032);
    wb(1'b0, 8'h8C, 32'h0);
    check(rd, 32'h0000_0000);
    wb(1'b0, 8'h90, 32'h0);
    check(rd, 32'(`RST_LOOP_CTRL));
    wb(1'b0, 8'h94, 32'h0);
    check(rd, 32'(`RST_LOOP_CTRL) >> `F_STAT_LO);
    repeat (4) begin
      v = $urandom;
      wb(1'b1, 8'h88, v);
      wb(1'b1, 8'h8C, v);
      wb(1'b1, 8'h90, {v[31:1], 1'b0});
      wb(1'b0, 8'h88, 32'h0);
      check(rd, v & 32'h0000_01FF);
      wb(1'b0, 8'h8C, 32'h0);
      check(rd, v & 32'h0000_000F);
      wb(1'b0, 8'h90, 32'h0);
      check(rd, v & 32'h0000_3FF0);
      wb(1'b0, 8'h94, 32'h0);
      check(rd, (v >> 8) & 32'h0000_003F);
    end
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    wb(1'b0, 8'hFC, 32'h0);
    check(rd, 32'h0000_0000);
    wb(1'b1, 8'h8C, 32'h0);
    $display("test registers done");
    ramp(9'h002, 16'h4000);
    ramp(9'h102, 16'h4000);
    ramp(9'h004, 16'h7001 + 16'($urandom % 16'h0FFE));
    ramp(9'h000, 16'h6000);
    ramp(9'h000, 16'h7800);
    ramp(9'h000, 16'h0400);
    ramp(9'h010, 16'h0400);
    $display("test ramps done");
    gate(4'h9, 6'h00);
    gate(4'hC, 6'h00);
    gate(4'hC, 6'h08);
    gate(4'h1, 6'h00);
    gate(4'hC, 6'h06 + 6'($urandom % 10));
    gate(4'hC, 6'($urandom % 5));
    $display("test gate done");
    report_and_stop();
  end
endmodule
`default_nettype wire
